// ### dma_ctl_pkg.sv
/*
  package for the four-channel dma start/stop controller: register offsets,
  field positions, reset values, transfer modes and timing constants.
  assumes a plain register port with one-cycle read latency.
*/
package dma_ctl_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned COUNT_W    = 16;

  // ==========================================================================
  // register offsets (byte addresses / 4)
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;  // channel control, 8 bits per channel
  localparam logic [ADDR_W-1:0] COUNT0_OFS = 4'h1;  // transfer count ch0..ch3 at 1..4
  localparam logic [ADDR_W-1:0] MODE_OFS   = 4'h5;  // 2 mode bits per channel
  localparam logic [ADDR_W-1:0] STAT_OFS   = 4'h6;  // sticky event status
  localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h7;  // interrupt mask
  localparam logic [ADDR_W-1:0] STATE_OFS  = 4'h8;  // engine state, read only

  // ==========================================================================
  // fields of the per-channel control byte
  localparam int unsigned CTL_BYTE   = 8;
  localparam int unsigned EN_POS     = 0;
  localparam int unsigned TCF_POS    = 1;
  localparam int unsigned STG_POS    = 2;
  localparam int unsigned INIT_POS   = 3;

  // status layout: bits 0..3 terminal count per channel, bit 4 stop seen
  localparam int unsigned STAT_W     = NUM_CH + 1;
  localparam int unsigned STOP_EVT   = NUM_CH;

  // ==========================================================================
  // reset values
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [STAT_W-1:0]  MASK_RST  = 5'h00;

  // ==========================================================================
  // transfer modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_STEP   = 2'h1;
  localparam logic [1:0] MODE_LINE   = 2'h2;
  localparam logic [1:0] MODE_BLOCK  = 2'h3;
  localparam int unsigned LINE_BEATS = 4;

  // ==========================================================================
  // timing: one transfer cycle on the system bus
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned XFER_NS     = 10;
  localparam int unsigned XFER_CYCLES =
    ((XFER_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (XFER_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_DONE
  } eng_state_e;

endpackage

// ### dma_requester_model.sv
/*
  requester model for the dma block: level request pins and the stop pin.
  assumes the bench arms channels and stop, one clock, active-low reset.
*/
`timescale 1ns/1ps
module dma_requester_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] arm_i,
  input  wire logic       stop_arm_i,
  input  wire logic [3:0] grant_i,
  input  wire logic [3:0] tc_i,
  output logic      [3:0] req_o,
  output logic            stop_o
);
  // ==========================================================================
  // requests and stop
  logic [1:0] dly_q;
  logic [2:0] stop_q;
  assign stop_o = (stop_q != 3'h0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 4'h0;
      dly_q <= 2'h0;
    end else begin
      dly_q <= 2'($urandom);
      for (int c = 0; c < 4; c++) begin
        if (tc_i[c] || !arm_i[c]) begin
          req_o[c] <= 1'b0;
        end else if (dly_q == 2'h0) begin
          req_o[c] <= 1'b1;
        end
      end
    end
  end
  // stop is raised while the bus is granted, before that transfer ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_q <= 3'h0;
    end else if (stop_q != 3'h0) begin
      stop_q <= stop_q - 3'h1;
    end else if (stop_arm_i && (grant_i != 4'h0)) begin
      stop_q <= 3'h6;
    end
  end
endmodule

// ### dma_start_stop_control.sv
/*
  dma start, terminal-count, interruption and termination control for four
  channels. assumes one clock, request and stop pins from outside the clock
  domain, and a register master that never issues read and write together.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
// Summary of operation
// - with enable 1 and terminal count 0, a hardware request in idle starts a transfer.
// - software trigger with enable 1 and terminal count 0 starts a transfer.
// - the terminal-count output pulses for exactly one clock in the last transfer cycle.
// - the stop input during a transfer clears the enable bit of every channel.
// - on stop the running transfer cycle is completed and the bus released; a stop first seen in a block or line cycle's last clock runs one more cycle.
// - after stop in single-step, line or block mode the request stays pending.
// - re-enabling after such a stop resumes with the remaining count kept.
// - after stop in single mode re-enabling waits for a fresh request.
// - a resumed transfer keeps its settings; software reprograms only after end or init.
// - writing init 1 terminates that channel's transfer.
// - init only acts on a channel that does not hold the bus; a running block cannot be terminated.
// - a count value of n performs n+1 transfers.
// - the completion state pulses terminal count, sets the terminal-count flag, keeps enable and returns to idle.
// - during a block transfer other channels' requests are ignored.
`timescale 1ns/1ps
module dma_start_stop_control
  import dma_ctl_pkg::*;
(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [NUM_CH-1:0] HW_TRANSFER_REQUEST_I,
  input  wire logic              DMA_STOP_INPUT_I,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  output logic      [NUM_CH-1:0] TERMINAL_COUNT_OUT_O,
  output logic      [NUM_CH-1:0] BUS_GRANT_O,
  output logic                   IRQ_O
);

  // ==========================================================================
  // input synchronisers
  logic [NUM_CH-1:0] req_s1_q, req_s2_q;
  logic              stp_s1_q, stp_s2_q;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_s1_q <= '0;
      req_s2_q <= '0;
      stp_s1_q <= 1'b0;
      stp_s2_q <= 1'b0;
    end else begin
      req_s1_q <= HW_TRANSFER_REQUEST_I;
      req_s2_q <= req_s1_q;
      stp_s1_q <= DMA_STOP_INPUT_I;
      stp_s2_q <= stp_s1_q;
    end
  end

  // ==========================================================================
  // state and registers
  eng_state_e            state_q;
  logic [1:0]            ch_q;
  logic [NUM_CH-1:0]     en_q, tcf_q, stg_q, pend_q;
  logic [COUNT_W-1:0]    cnt_q [NUM_CH];
  logic [2*NUM_CH-1:0]   mode_q;
  logic [STAT_W-1:0]     stat_q, mask_q;
  logic [2:0]            beat_q;
  logic [7:0]            tmr_q;
  logic                  stop_q;

  function automatic logic [1:0] ch_mode(input logic [2*NUM_CH-1:0] m, input logic [1:0] c);
    ch_mode = m[2*c +: 2];
  endfunction

  function automatic logic [1:0] pick(input logic [NUM_CH-1:0] v);
    pick = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = i[1:0];
      end
    end
  endfunction

  logic             wr_ctl, wr_mode, wr_stat, wr_mask;
  logic [NUM_CH-1:0] wr_cnt;
  logic [NUM_CH-1:0] ready, init_w;
  logic [1:0]       cur_mode;
  logic             last_cycle, beat_end, bus_free;

  assign wr_ctl  = REG_WR_I && (REG_ADDR_I == CTRL_OFS);
  assign wr_mode = REG_WR_I && (REG_ADDR_I == MODE_OFS);
  assign wr_stat = REG_WR_I && (REG_ADDR_I == STAT_OFS);
  assign wr_mask = REG_WR_I && (REG_ADDR_I == MASK_OFS);
  assign bus_free = (state_q == ST_IDLE);
  assign cur_mode = ch_mode(mode_q, ch_q);
  assign beat_end = (state_q == ST_XFER) && (tmr_q == 8'(XFER_CYCLES - 1));
  assign last_cycle = beat_end && (cnt_q[ch_q] == COUNT_RST);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign wr_cnt[g] = REG_WR_I && (REG_ADDR_I == 4'(COUNT0_OFS + g));
    assign init_w[g] = wr_ctl && REG_WDATA_I[g*CTL_BYTE + INIT_POS] &&
                       !(state_q != ST_IDLE && ch_q == g);
    assign ready[g] = en_q[g] && !tcf_q[g] && (req_s2_q[g] || stg_q[g] || pend_q[g]);
  end

  // ==========================================================================
  // engine sequencer
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      ch_q    <= 2'h0;
      tmr_q   <= 8'h00;
      beat_q  <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          tmr_q  <= 8'h00;
          beat_q <= 3'h0;
          if (|ready) begin
            state_q <= ST_XFER;
            ch_q    <= pick(ready);
          end
        end
        ST_XFER: begin
          // other channels are not looked at until this one releases
          tmr_q <= beat_end ? 8'h00 : tmr_q + 8'h01;
          if (beat_end) begin
            beat_q <= beat_q + 3'h1;
            // stop_q lets the running cycle finish, then releases; a stop first seen at beat_end is not yet in stop_q
            if (last_cycle) begin
              state_q <= ST_DONE;
            end else if (stop_q || cur_mode == MODE_SINGLE || cur_mode == MODE_STEP ||
                         (cur_mode == MODE_LINE && beat_q == 3'(LINE_BEATS - 1))) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // stop latch, held until the bus is released
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stop_q <= 1'b0;
    end else if (stp_s2_q && state_q == ST_XFER) begin
      stop_q <= 1'b1;
    end else if (state_q != ST_XFER) begin
      stop_q <= 1'b0;
    end
  end

  // ==========================================================================
  // channel control bits
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q   <= '0;
      tcf_q  <= '0;
      stg_q  <= '0;
      pend_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_ctl) begin
          en_q[i]  <= REG_WDATA_I[i*CTL_BYTE + EN_POS];
          stg_q[i] <= REG_WDATA_I[i*CTL_BYTE + STG_POS];
          if (!REG_WDATA_I[i*CTL_BYTE + TCF_POS]) begin
            tcf_q[i] <= 1'b0;
          end
        end
        if (init_w[i]) begin
          en_q[i]   <= 1'b0;
          stg_q[i]  <= 1'b0;
          pend_q[i] <= 1'b0;
        end
        if (state_q == ST_XFER && beat_end && ch_q == i) begin
          stg_q[i] <= 1'b0;
          // after a stop keep the request for step, line and block, drop it for single
          pend_q[i] <= !last_cycle && (stop_q || stp_s2_q) && cur_mode != MODE_SINGLE;
          if (last_cycle) begin
            tcf_q[i] <= 1'b1;
          end
        end
        if (stp_s2_q && state_q == ST_XFER) begin
          en_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // transfer counts; a stopped channel keeps its remainder
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cnt
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        cnt_q[g] <= COUNT_RST;
      end else if (beat_end && ch_q == g && !last_cycle) begin
        cnt_q[g] <= cnt_q[g] - 16'h0001;
      end else if (wr_cnt[g] && !(state_q != ST_IDLE && ch_q == g)) begin
        cnt_q[g] <= REG_WDATA_I[COUNT_W-1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_q <= '0;
    end else if (wr_mode && bus_free) begin
      mode_q <= REG_WDATA_I[2*NUM_CH-1:0];
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TERMINAL_COUNT_OUT_O <= '0;
      BUS_GRANT_O          <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        TERMINAL_COUNT_OUT_O[i] <= last_cycle && ch_q == i;
        // grant covers every clock of the channel's transfer cycles
        BUS_GRANT_O[i]          <= state_q == ST_XFER && ch_q == i;
      end
    end
  end

  // ==========================================================================
  // interrupt status, set wins over clear
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_q <= '0;
      mask_q <= MASK_RST;
      IRQ_O  <= 1'b0;
    end else begin
      for (int i = 0; i < STAT_W; i++) begin
        if (i < NUM_CH ? (last_cycle && ch_q == i) : (stp_s2_q && state_q == ST_XFER)) begin
          stat_q[i] <= 1'b1;
        end else if (wr_stat && REG_WDATA_I[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (wr_mask) begin
        mask_q <= REG_WDATA_I[STAT_W-1:0];
      end
      IRQ_O <= |(stat_q & mask_q);
    end
  end

  // ==========================================================================
  // read data
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= '0;
    end else begin
      REG_RDATA_O <= '0;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          CTRL_OFS: begin
            for (int i = 0; i < NUM_CH; i++) begin
              REG_RDATA_O[i*CTL_BYTE + EN_POS]  <= en_q[i];
              REG_RDATA_O[i*CTL_BYTE + TCF_POS] <= tcf_q[i];
              REG_RDATA_O[i*CTL_BYTE + STG_POS] <= stg_q[i];
            end
          end
          4'h1, 4'h2, 4'h3, 4'h4: REG_RDATA_O[COUNT_W-1:0] <= cnt_q[2'(REG_ADDR_I - COUNT0_OFS)];
          MODE_OFS:  REG_RDATA_O[2*NUM_CH-1:0] <= mode_q;
          STAT_OFS:  REG_RDATA_O[STAT_W-1:0]   <= stat_q;
          MASK_OFS:  REG_RDATA_O[STAT_W-1:0]   <= mask_q;
          STATE_OFS: REG_RDATA_O[3:0]          <= {ch_q, state_q};
          default:   REG_RDATA_O <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // checks
  tc_one_clock_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    TERMINAL_COUNT_OUT_O[0] |=> !TERMINAL_COUNT_OUT_O[0])
    else $error("terminal count longer than one clock");

  hw_start_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (state_q == ST_IDLE && |ready) |=> state_q == ST_XFER)
    else $error("ready channel not started");

  no_start_tc_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (state_q == ST_IDLE && tcf_q[0] && ch_q != 2'h0) |=> !(state_q == ST_XFER && ch_q == 2'h0))
    else $error("start despite terminal count flag");

  stop_clears_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (stp_s2_q && state_q == ST_XFER && !wr_ctl) |=> en_q == '0)
    else $error("stop left a channel enabled");

  done_idle_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    state_q == ST_DONE |=> state_q == ST_IDLE)
    else $error("completion did not return to idle");

  tc_sets_flag_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (last_cycle && ch_q == 2'h0) |=> tcf_q[0] && TERMINAL_COUNT_OUT_O[0])
    else $error("terminal count flag not set");

  block_holds_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (state_q == ST_XFER && cur_mode == MODE_BLOCK && !beat_end) |=> $stable(ch_q))
    else $error("block transfer lost the bus");

  stop_release_a : assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (stop_q && beat_end) |=> state_q != ST_XFER)
    else $error("stop did not release the bus");

endmodule

// ### tb.sv
/*
  self-checking bench for the dma start/stop control block.
  assumes the requester model on the pins and a register master in the bench.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  import dma_ctl_pkg::*;
  // ==========================================================================
  // signals
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [3:0]        req;
  logic              stop;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr_s = 1'b0;
  logic              rd_s = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        tc;
  logic [3:0]        gnt;
  logic              irq;
  logic [3:0]        arm = 4'h0;
  logic              stop_arm = 1'b0;
  logic [3:0]        tc_p = 4'h0;
  logic [DATA_W-1:0] v;
  int                mismatches = 0;
  int                n_checks = 0;
  int                tc_cnt[4] = '{0, 0, 0, 0};
  int                gnt_cnt[4] = '{0, 0, 0, 0};
  int                dbl = 0;
  int                n;
  int                b;

  initial begin
    forever #2.5 clk = ~clk;
  end

  dma_start_stop_control dma_start_stop_control_inst (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .HW_TRANSFER_REQUEST_I(req),
    .DMA_STOP_INPUT_I(stop), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
    .TERMINAL_COUNT_OUT_O(tc), .BUS_GRANT_O(gnt), .IRQ_O(irq));
  dma_requester_model dma_requester_model_inst (
    .clk_i(clk), .rst_n_i(rst_n), .arm_i(arm), .stop_arm_i(stop_arm),
    .grant_i(gnt), .tc_i(tc), .req_o(req), .stop_o(stop));

  // ==========================================================================
  // monitor and tasks
  always @(posedge clk) begin
    tc_p <= tc;
    if ((tc & tc_p) != 4'h0) dbl++;
    for (int c = 0; c < 4; c++) begin
      if (tc[c] === 1'b1) tc_cnt[c]++;
      if (gnt[c] === 1'b1) gnt_cnt[c]++;
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_tc(input int c, input int lim);
    int s;
    s = tc_cnt[c];
    for (int i = 0; i < lim && tc_cnt[c] == s; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic stop_run();
    stop_arm <= 1'b1;
    wr(CTRL_OFS, 32'h05000000);
    for (int i = 0; i < 60 && stop !== 1'b1; i++) @(posedge clk);
    stop_arm <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #50us;
    mismatches++;
    summarize();
  end

  // ==========================================================================
  // tests
  initial begin
    void'($urandom(66));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("tc rst", 4'h0, tc)
    `CHK("irq rst", 1'b0, irq)
    wr(4'h9, 32'hffffffff);
    rd(4'h9, v);
    `CHK("unmapped", 32'h0, v)
    rd(MASK_OFS, v);
    `CHK("mask rst", 32'h0, v)
    rd(COUNT0_OFS, v);
    `CHK("count rst", 32'h0, v)
    wr(CTRL_OFS, 32'h05);
    wait_tc(0, 50);
    `CHK("sw start", 1, tc_cnt[0])
    `CHK("one beat", XFER_CYCLES, gnt_cnt[0])
    rd(CTRL_OFS, v);
    `CHK("flag", 1'b1, v[TCF_POS])
    wr(CTRL_OFS, 32'h07);
    repeat (20) @(posedge clk);
    `CHK("blocked", 1, tc_cnt[0])
    rd(STAT_OFS, v);
    `CHK("status", 5'h01, v[4:0])
    wr(MASK_OFS, 32'h01);
    repeat (3) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    wr(STAT_OFS, 32'h1f);
    repeat (3) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    n = $urandom % 6;
    wr(COUNT0_OFS + 4'h2, 32'(n));
    wr(MODE_OFS, 32'h30);
    wr(CTRL_OFS, 32'h050000);
    wait_tc(2, 200);
    `CHK("block n", (n + 1) * XFER_CYCLES, gnt_cnt[2])
    wr(COUNT0_OFS + 4'h1, 32'h7);
    wr(MODE_OFS, 32'h0c);
    wr(CTRL_OFS, 32'h0501);
    for (int i = 0; i < 50 && gnt[1] !== 1'b1; i++) @(posedge clk);
    arm <= 4'h1;
    wr(CTRL_OFS, 32'h0d01);
    b = gnt_cnt[0];
    for (int i = 0; i < 200 && tc[1] !== 1'b1; i++) @(posedge clk);
    `CHK("ignored", b, gnt_cnt[0])
    repeat (2) @(posedge clk);
    `CHK("no init", 8 * XFER_CYCLES, gnt_cnt[1])
    wait_tc(0, 100);
    `CHK("hw start", 2, tc_cnt[0])
    arm <= 4'h0;
    wr(COUNT0_OFS + 4'h3, 32'h5);
    wr(MODE_OFS, 32'hc0);
    stop_run();
    `CHK("stopped", 0, tc_cnt[3])
    `CHK("released", 4'h0, gnt)
    `CHK("whole beats", 0, gnt_cnt[3] % XFER_CYCLES)
    rd(CTRL_OFS, v);
    `CHK("en cleared", 1'b0, v[24 + EN_POS])
    rd(STAT_OFS, v);
    `CHK("stop seen", 1'b1, v[STOP_EVT])
    wr(CTRL_OFS, 32'h01000000);
    wait_tc(3, 200);
    `CHK("resumed", 1, tc_cnt[3])
    `CHK("kept count", 6 * XFER_CYCLES, gnt_cnt[3])
    wr(COUNT0_OFS + 4'h3, 32'h5);
    stop_run();
    wr(CTRL_OFS, 32'h08000000);
    wr(CTRL_OFS, 32'h01000000);
    repeat (100) @(posedge clk);
    `CHK("terminated", 1, tc_cnt[3])
    `CHK("tc width", 0, dbl)
    summarize();
  end
endmodule
